// ---- verilog/rx_bypass_phase_delay_align.sv ----
// rx buffer-bypass phase and delay alignment control with apb registers
`timescale 1ns/1ps
module rx_bypass_phase_delay_align
   import rx_align_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        align_power_down,
   input  wire logic        phase_count_override_en,
   input  wire logic        delay_soft_reset,
   input  wire logic        delay_align_skip,
   input  wire logic        delay_align_enable,
   input  wire logic        delay_count_override_en,
   input  wire logic        phase_align_request,
   input  wire logic [4:0]  phase_target,
   output logic             delay_soft_reset_done,
   output logic             phase_align_done,
   output logic [8:0]       delay_tap,
   output logic             irq
);
   align_regs_t r_ff;
   align_regs_t nxt_r;
   align_ctl_t  pins;
   logic [4:0]  ph_val;
   logic        ph_locked;
   logic        ph_run;
   logic [8:0]  span;
   logic [8:0]  centre;
   logic        wr;
   logic        rd;
   logic [1:0]  ev;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction

   assign pins.power_down   = align_power_down;
   assign pins.phase_ovr_en = phase_count_override_en;
   assign pins.soft_reset   = delay_soft_reset;
   assign pins.delay_skip   = delay_align_skip;
   assign pins.delay_en     = delay_align_enable;
   assign pins.delay_ovr_en = delay_count_override_en;
   assign pins.phase_req    = phase_align_request;

   assign span   = r_ff.ctrl[CTRL_FULL_RNG_BIT] ? TAP_FULL_SPAN
                                                : TAP_HALF_SPAN;
   assign centre = {1'b0, span[8:1]};
   assign ph_run = (r_ff.state == ST_PH1) || (r_ff.state == ST_PH2);
   assign wr     = psel && penable && pwrite;
   assign rd     = psel && penable && !pwrite;

   rx_phase_tracker u_phase
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (ph_run),
      .ovr_en    (r_ff.s2.phase_ovr_en),
      .ovr_val   (r_ff.phcfg[PH_OVR_LSB +: PH_OVR_W]),
      .target    (phase_target),
      .phase_ff  (ph_val),
      .locked_ff (ph_locked)
   );

   always_comb
   begin
      nxt_r        = r_ff;
      ev           = 2'b00;
      nxt_r.s1     = pins;
      nxt_r.s2     = r_ff.s1;
      nxt_r.srst_q = r_ff.s2.soft_reset;
      nxt_r.pready = 1'b0;
      nxt_r.pslverr = 1'b0;
      nxt_r.phase  = ph_val;

      if (r_ff.s2.power_down || r_ff.ctrl[CTRL_BUF_USE_BIT])
      begin
         nxt_r.state     = ST_OFF;
         nxt_r.srst_done = 1'b0;
         nxt_r.ph_done   = 1'b0;
      end
      else
      begin
         unique case (r_ff.state)
            ST_OFF:
            begin
               nxt_r.state = ST_IDLE;
            end
            ST_IDLE, ST_DONE:
            begin
               // automatic start needs every other input low
               if (r_ff.s2.soft_reset && !r_ff.srst_q &&
                   !r_ff.s2.phase_ovr_en && !r_ff.s2.delay_en &&
                   !r_ff.s2.delay_ovr_en && !r_ff.s2.phase_req &&
                   !r_ff.s2.delay_skip)
               begin
                  nxt_r.state     = ST_CENTRE;
                  nxt_r.srst_done = 1'b0;
                  nxt_r.ph_done   = 1'b0;
               end
            end
            ST_CENTRE:
            begin
               if (r_ff.tap == centre)
               begin
                  nxt_r.srst_done = 1'b1;
                  ev[IRQ_SRST_DONE] = 1'b1;
                  nxt_r.state     = ST_PH1;
               end
               else if (r_ff.tap < centre)
               begin
                  nxt_r.tap = r_ff.tap + 9'h001;
               end
               else
               begin
                  nxt_r.tap = r_ff.tap - 9'h001;
               end
            end
            ST_PH1:
            begin
               if (ph_locked)
               begin
                  nxt_r.ph_done = 1'b1; // first rising edge
                  nxt_r.state   = ST_DLY;
               end
            end
            ST_DLY:
            begin
               nxt_r.ph_done = 1'b0;
               if (r_ff.s2.delay_skip)
               begin
                  nxt_r.state = ST_PH2;
               end
               else if (r_ff.s2.delay_ovr_en)
               begin
                  nxt_r.tap   = r_ff.dlycfg[DLY_OVR_LSB +: DLY_OVR_W];
                  nxt_r.state = ST_PH2;
               end
               else
               begin
                  // fine delay trim from the locked phase
                  nxt_r.tap   = centre + {4'h0, ph_val} - 9'h010;
                  nxt_r.state = ST_PH2;
               end
            end
            ST_PH2:
            begin
               if (ph_locked)
               begin
                  nxt_r.ph_done   = 1'b1; // second rising edge
                  ev[IRQ_ALIGNED] = 1'b1;
                  nxt_r.state     = ST_DONE;
               end
            end
            default:
            begin
               nxt_r.state = ST_OFF;
            end
         endcase
      end
      // override takes effect whenever its enable is high and delay skip is low
      if (r_ff.s2.delay_ovr_en && !r_ff.s2.delay_skip)
      begin
         nxt_r.tap = r_ff.dlycfg[DLY_OVR_LSB +: DLY_OVR_W];
      end
      if (nxt_r.tap > span)
      begin
         nxt_r.tap = span;
      end

      // apb access, one wait state
      if (psel && penable && !r_ff.pready)
      begin
         nxt_r.pready = 1'b1;
      end
      if (wr && r_ff.pready)
      begin
         if (hit(paddr, CTRL_OFS))
            nxt_r.ctrl = pwdata[1:0];
         else if (hit(paddr, PHCFG_OFS))
            nxt_r.phcfg = pwdata[PH_CFG_W-1:0];
         else if (hit(paddr, DLYCFG_OFS))
            nxt_r.dlycfg = pwdata[DLY_CFG_W-1:0];
         else if (hit(paddr, IRQ_EN_OFS))
            nxt_r.irq_en = pwdata[IRQ_W-1:0];
         else if (hit(paddr, IRQ_CLR_OFS))
            nxt_r.irq_st = r_ff.irq_st & ~pwdata[IRQ_W-1:0];
         else if (!hit(paddr, STAT_OFS) && !hit(paddr, IRQ_ST_OFS) &&
                  !hit(paddr, TAP_OFS))
            nxt_r.pslverr = 1'b0;
      end
      if (psel && penable && !r_ff.pready)
      begin
         nxt_r.pslverr = !(hit(paddr, CTRL_OFS) || hit(paddr, PHCFG_OFS) ||
                           hit(paddr, DLYCFG_OFS) || hit(paddr, STAT_OFS) ||
                           hit(paddr, IRQ_ST_OFS) || hit(paddr, IRQ_EN_OFS) ||
                           hit(paddr, IRQ_CLR_OFS) || hit(paddr, TAP_OFS));
         nxt_r.prdata = 32'h00000000;
         if (!pwrite)
         begin
            if (hit(paddr, CTRL_OFS))
               nxt_r.prdata = {30'h0, r_ff.ctrl};
            else if (hit(paddr, PHCFG_OFS))
               nxt_r.prdata = {8'h00, r_ff.phcfg};
            else if (hit(paddr, DLYCFG_OFS))
               nxt_r.prdata = {16'h0000, r_ff.dlycfg};
            else if (hit(paddr, STAT_OFS))
               nxt_r.prdata = {22'h0, r_ff.phase, r_ff.state,
                               r_ff.ph_done, r_ff.srst_done};
            else if (hit(paddr, IRQ_ST_OFS))
               nxt_r.prdata = {30'h0, r_ff.irq_st};
            else if (hit(paddr, IRQ_EN_OFS))
               nxt_r.prdata = {30'h0, r_ff.irq_en};
            else if (hit(paddr, TAP_OFS))
               nxt_r.prdata = {23'h0, r_ff.tap};
         end
      end
      else if (!rd)
      begin
         nxt_r.prdata = 32'h00000000;
      end
      // set wins over clear
      nxt_r.irq_st = nxt_r.irq_st | ev;
      nxt_r.irq    = |(nxt_r.irq_st & nxt_r.irq_en);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_ff        <= '0;
         r_ff.state  <= ST_OFF;
         r_ff.ctrl   <= CTRL_RST;
         r_ff.phcfg  <= PHCFG_RST;
         r_ff.dlycfg <= DLYCFG_RST;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

   assign prdata                = r_ff.prdata;
   assign pready                = r_ff.pready;
   assign pslverr               = r_ff.pslverr;
   assign delay_soft_reset_done = r_ff.srst_done;
   assign phase_align_done      = r_ff.ph_done;
   assign delay_tap             = r_ff.tap;
   assign irq                   = r_ff.irq;
endmodule

// ---- inc/rx_align_pkg.sv ----
// package of constants, types and registers for the rx bypass alignment block
// Operation
// - power-down input stops the alignment circuit; low powers it up.
// - phase override enable loads phase counter from config bits 10:6.
// - delay soft reset walks the delay tap gradually to its centre.
// - delay tap spans +-4 ns full range or +-2 ns half range.
// - soft reset with other inputs low starts automatic alignment.
// - delay skip bypasses delay alignment; low uses it.
// - delay override enable loads delay counter from config bits 14:6.
// - delay soft reset done rises when the soft reset completes.
// - second phase-done rising edge after soft-reset-done marks completion.
// - alignment controls act only when the elastic buffer is bypassed; the delay and phase overrides here also act while it is in use.
package rx_align_pkg;
   // apb register offsets
   localparam logic [11:0] CTRL_OFS    = 12'h000;
   localparam logic [11:0] PHCFG_OFS   = 12'h004;
   localparam logic [11:0] DLYCFG_OFS  = 12'h008;
   localparam logic [11:0] STAT_OFS    = 12'h00C;
   localparam logic [11:0] IRQ_ST_OFS  = 12'h010;
   localparam logic [11:0] IRQ_EN_OFS  = 12'h014;
   localparam logic [11:0] IRQ_CLR_OFS = 12'h018;
   localparam logic [11:0] TAP_OFS     = 12'h01C;
   // control register fields
   localparam int CTRL_BUF_USE_BIT  = 0;
   localparam int CTRL_FULL_RNG_BIT = 1;
   // config vector field positions
   localparam int PH_OVR_LSB  = 6;
   localparam int PH_OVR_W    = 5;
   localparam int DLY_OVR_LSB = 6;
   localparam int DLY_OVR_W   = 9;
   localparam int PH_CFG_W    = 24;
   localparam int DLY_CFG_W   = 16;
   // interrupt bits
   localparam int IRQ_SRST_DONE = 0;
   localparam int IRQ_ALIGNED   = 1;
   localparam int IRQ_W         = 2;
   // reset values
   localparam logic [1:0]  CTRL_RST   = 2'h1;
   localparam logic [23:0] PHCFG_RST  = 24'h000000;
   localparam logic [15:0] DLYCFG_RST = 16'h0000;
   // delay tap: one step per cycle, range in ns and step in ps
   localparam int TAP_FULL_NS = 4;
   localparam int TAP_HALF_NS = 2;
   localparam int TAP_STEP_PS = 16;
   localparam logic [8:0] TAP_FULL_SPAN =
      9'(2 * TAP_FULL_NS * 1000 / TAP_STEP_PS - 1);
   localparam logic [8:0] TAP_HALF_SPAN =
      9'(2 * TAP_HALF_NS * 1000 / TAP_STEP_PS - 1);
   // phase lock: cycles the phase counter must sit still
   localparam logic [4:0] PH_SETTLE = 5'h08;

   typedef enum logic [2:0]
   {
      ST_OFF    = 3'b000,
      ST_IDLE   = 3'b001,
      ST_CENTRE = 3'b010,
      ST_PH1    = 3'b011,
      ST_DLY    = 3'b100,
      ST_PH2    = 3'b101,
      ST_DONE   = 3'b110
   } align_state_t;

   // synchronised pin inputs
   typedef struct packed
   {
      logic power_down;
      logic phase_ovr_en;
      logic soft_reset;
      logic delay_skip;
      logic delay_en;
      logic delay_ovr_en;
      logic phase_req;
   } align_ctl_t;

   typedef struct packed
   {
      align_ctl_t   s1;
      align_ctl_t   s2;
      logic         srst_q;
      align_state_t state;
      logic [8:0]   tap;
      logic [4:0]   phase;
      logic [4:0]   settle;
      logic         srst_done;
      logic         ph_done;
      logic [1:0]   ctrl;
      logic [23:0]  phcfg;
      logic [15:0]  dlycfg;
      logic [1:0]   irq_st;
      logic [1:0]   irq_en;
      logic         irq;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
   } align_regs_t;
endpackage

// ---- verilog/rx_phase_tracker.sv ----
// phase counter that walks toward the sampled target and reports lock
`timescale 1ns/1ps
module rx_phase_tracker
   import rx_align_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic       ovr_en,
   input  wire logic [4:0] ovr_val,
   input  wire logic [4:0] target,
   output logic [4:0]      phase_ff,
   output logic            locked_ff
);
   logic [4:0] nxt_phase;
   logic [4:0] settle_ff;
   logic [4:0] nxt_settle;
   logic       nxt_locked;

   always_comb
   begin
      nxt_phase  = phase_ff;
      nxt_settle = settle_ff;
      nxt_locked = 1'b0;
      // override wins whether or not an alignment step is running
      if (ovr_en)
      begin
         nxt_phase  = ovr_val;
         nxt_settle = 5'h00;
      end
      else if (!run)
      begin
         nxt_settle = 5'h00;
      end
      else if (phase_ff != target)
      begin
         nxt_phase  = (phase_ff < target) ? phase_ff + 5'h01
                                          : phase_ff - 5'h01;
         nxt_settle = 5'h00;
      end
      else if (settle_ff != PH_SETTLE)
      begin
         nxt_settle = settle_ff + 5'h01;
      end
      else
      begin
         nxt_locked = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_ff  <= 5'h00;
         settle_ff <= 5'h00;
         locked_ff <= 1'b0;
      end
      else
      begin
         phase_ff  <= nxt_phase;
         settle_ff <= nxt_settle;
         locked_ff <= nxt_locked;
      end
   end
endmodule

// ---- bench/fabric_ctl.sv ----
// fabric-side model that sequences the alignment pins
`timescale 1ns/1ps
module fabric_ctl
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic start,
   input  wire logic pd,
   input  wire logic dovr,
   input  wire logic povr,
   input  wire logic skip,
   input  wire logic delay_soft_reset_done,
   input  wire logic phase_align_done,
   output logic      align_power_down,
   output logic      phase_count_override_en,
   output logic      delay_soft_reset,
   output logic      delay_align_skip,
   output logic      delay_align_enable,
   output logic      delay_count_override_en,
   output logic      phase_align_request,
   output logic      aligned
);
   logic [1:0] s_ff;
   logic [2:0] p_ff;
   logic [1:0] cnt_ff;
   assign align_power_down        = pd;
   assign delay_soft_reset        = start & ~pd;
   assign delay_align_skip        = skip;
   assign delay_align_enable      = 1'b0;
   assign delay_count_override_en = dovr;
   assign phase_count_override_en = povr;
   assign phase_align_request     = 1'b0;
   // data users wait for aligned, as byte order may shift before it
   assign aligned                 = cnt_ff == 2'h2;
   // done flags are synchronised before their edges are counted
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         s_ff   <= 2'h0;
         p_ff   <= 3'h0;
         cnt_ff <= 2'h0;
      end
      else
      begin
         s_ff <= {s_ff[0], delay_soft_reset_done};
         p_ff <= {p_ff[1:0], phase_align_done};
         if (start)
            cnt_ff <= 2'h0;
         else if (s_ff[1] && p_ff[1] && !p_ff[2] && !aligned)
            cnt_ff <= cnt_ff + 2'h1;
      end
endmodule

// ---- bench/align_checker.sv ----
// concurrent checks on the ports of the alignment block
`timescale 1ns/1ps
module align_checker
   import rx_align_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        align_power_down,
   input wire logic        delay_soft_reset_done,
   input wire logic        phase_align_done,
   input wire logic [8:0]  delay_tap,
   input wire logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy_wait;
      psel && penable && !$past(penable) |=> pready;
   endproperty
   a_rdy_wait: assert property (p_rdy_wait) else $error("no pready");
   property p_rdy_pulse;
      pready |=> !pready;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("long pready");
   property p_err_map;
      pready |-> pslverr == (paddr > TAP_OFS);
   endproperty
   a_err_map: assert property (p_err_map) else $error("bad pslverr");
   property p_err_only;
      pslverr |-> pready;
   endproperty
   a_err_only: assert property (p_err_only) else $error("stray pslverr");
   property p_pd_off;
      align_power_down [*5] |-> !delay_soft_reset_done && !phase_align_done;
   endproperty
   a_pd_off: assert property (p_pd_off) else $error("flags in pd");
   property p_walk;
      $rose(delay_soft_reset_done) |->
         ($past(delay_tap) - $past(delay_tap, 2)) inside
            {9'h000, 9'h001, 9'h1FF};
   endproperty
   a_walk: assert property (p_walk) else $error("tap jumped");
   property p_order;
      phase_align_done |-> delay_soft_reset_done;
   endproperty
   a_order: assert property (p_order) else $error("early phase");
   property p_relock;
      $fell(phase_align_done) && delay_soft_reset_done && !align_power_down
         |-> ##[1:200] phase_align_done;
   endproperty
   a_relock: assert property (p_relock) else $error("no relock");
   property p_irq_src;
      $rose(irq) |-> delay_soft_reset_done || phase_align_done;
   endproperty
   a_irq_src: assert property (p_irq_src) else $error("stray irq");
endmodule
bind rx_bypass_phase_delay_align align_checker u_chk (.*);

// ---- bench/testbench.sv ----
// self-checking bench for the rx bypass alignment block
`timescale 1ns/1ps
module testbench;
   import rx_align_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic        align_power_down, phase_count_override_en, irq, err;
   logic        delay_soft_reset, delay_align_skip, delay_align_enable;
   logic        delay_count_override_en, phase_align_request;
   logic        delay_soft_reset_done, phase_align_done;
   logic [4:0]  phase_target;
   logic [8:0]  delay_tap;
   logic        start, pd, dovr, povr, skip, aligned;
   int          mismatches, checks_done;
   rx_bypass_phase_delay_align DUT (.*);
   fabric_ctl u_far (.*);
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] centre(input logic full);
      return 32'(full ? TAP_FULL_SPAN / 2 : TAP_HALF_SPAN / 2);
   endfunction
   // final tap: centre, or centre trimmed by the locked phase around 16
   function automatic logic [31:0] end_tap(input logic full, input logic sk,
                                           input logic [4:0] t);
      return sk ? centre(full) : centre(full) + 32'(t) - 32'h10;
   endfunction
   // override value is clipped to the full-range span
   function automatic logic [31:0] ovr_tap(input logic [8:0] v);
      return (v > TAP_FULL_SPAN) ? 32'(TAP_FULL_SPAN) : 32'(v);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         mismatches++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic run_align(input logic sk, input logic full);
      int n;
      logic [8:0] ctap;
      ctap = '1;
      start <= 1'b1;
      repeat (4) @(posedge pclk);
      start <= 1'b0;
      skip  <= sk;
      for (n = 0; n < 3000 && aligned !== 1'b1; n++)
      begin
         // tap seen just before soft-reset done rises
         if (delay_soft_reset_done !== 1'b1)
            ctap = delay_tap;
         @(posedge pclk);
      end
      skip <= 1'b0;
      chk(aligned, 1'b1);
      chk(ctap, centre(full));
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #(25 * 40000);
      mismatches++;
      test_done();
   end
   initial
   begin
      {psel, penable, pwrite, start, pd, dovr, povr, skip} = '0;
      paddr = '0;
      pwdata = '0;
      phase_target = 5'h00;
      mismatches = 0;
      checks_done = 0;
      seed = 32'h00011A04;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(CTRL_OFS, 32'(CTRL_RST));
      rchk(PHCFG_OFS, 32'(PHCFG_RST));
      rchk(DLYCFG_OFS, 32'(DLYCFG_RST));
      apb(1'b0, 12'hFFC, 32'h0);
      chk(rd, 32'h00000000);
      chk(err, 1'b1);
      // buffer still in use, so a soft reset is ignored
      start <= 1'b1;
      repeat (40) @(posedge pclk);
      start <= 1'b0;
      chk(delay_soft_reset_done, 1'b0);
      $display("test done: reset values and refusal");
      apb(1'b1, IRQ_EN_OFS, 32'h3);
      for (int r = 0; r < 2; r++)
      begin
         apb(1'b1, CTRL_OFS, 32'(r * 2));
         seed = nx(seed);
         phase_target <= seed[4:0];
         run_align(r[0], r[0]);
         chk(delay_soft_reset_done, 1'b1);
         chk(phase_align_done, 1'b1);
         chk(delay_tap, end_tap(r[0], r[0], phase_target));
         rchk(IRQ_ST_OFS, 32'h3);
         chk(irq, r == 0);
         apb(1'b1, IRQ_EN_OFS, 32'h3);
         repeat (2) @(posedge pclk);
         chk(irq, 1'b1);
         apb(1'b1, IRQ_CLR_OFS, 32'h3);
         repeat (2) @(posedge pclk);
         chk(irq, 1'b0);
         rchk(IRQ_ST_OFS, 32'h0);
         apb(1'b1, IRQ_EN_OFS, 32'h0);
      end
      $display("test done: automatic alignment and interrupts");
      for (int i = 0; i < 3; i++)
      begin
         seed = nx(seed);
         apb(1'b1, DLYCFG_OFS, 32'(seed[15:0]));
         apb(1'b1, PHCFG_OFS, 32'(seed[31:8]));
         dovr <= 1'b1;
         povr <= 1'b1;
         repeat (6) @(posedge pclk);
         chk(delay_tap, ovr_tap(seed[14:6]));
         apb(1'b0, STAT_OFS, 32'h0);
         chk(rd[9:5], seed[18:14]);
         dovr <= 1'b0;
         povr <= 1'b0;
      end
      $display("test done: counter overrides");
      pd <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({delay_soft_reset_done, phase_align_done}, 2'h0);
      pd <= 1'b0;
      repeat (4) @(posedge pclk);
      run_align(1'b0, 1'b1);
      $display("test done: power down");
      test_done();
   end
endmodule
